/* common/fault_ovr_pkg.sv */
package fault_ovr_pkg;
   // register indices on the plain register port
   localparam logic [3:0] FAULT_CTRL_ADDR   = 4'h0; // polarity, mode, override values
   localparam logic [3:0] OUT_CTRL_ADDR     = 4'h1; // output control register
   localparam logic [3:0] LOCK_KEY_ADDR     = 4'h2; // unlock sequence key writes
   localparam logic [3:0] STATUS_ADDR       = 4'h3; // fault state, sticky events
   localparam logic [3:0] IRQ_MASK_ADDR     = 4'h4;
   localparam logic [3:0] CLEAR_ADDR        = 4'h5; // write 1 to bit 0 releases latch
   // fault control field positions
   localparam int POL_BIT      = 2;
   localparam int MODE_LSB     = 0;
   localparam int OVR_HI_BIT   = 4;
   localparam int OVR_LO_BIT   = 5;
   // fault mode encodings
   localparam logic [1:0] MODE_LATCHED  = 2'h0;
   localparam logic [1:0] MODE_CYCLE    = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_DISABLED = 2'h3;
   // reset values
   localparam logic [15:0] FAULT_CTRL_RST = 16'h0003;
   localparam logic [15:0] OUT_CTRL_RST   = 16'h0000;
   localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
   // unlock keys, written back to back
   localparam logic [15:0] UNLOCK_KEY1    = 16'habcd;
   localparam logic [15:0] UNLOCK_KEY2    = 16'h4321;
   // status bits
   localparam int ST_FORCED    = 0;
   localparam int ST_LATCHED   = 1;
   localparam int EV_FAULT     = 2;
   localparam int EV_LOCKREJ   = 3;
endpackage

/* hw/unlock_seq.sv */
`timescale 1ns/1ps
// two-key unlock: key1 then key2 on consecutive key writes opens one write window
module unlock_seq
   import fault_ovr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        key_wr,
   input  wire logic [15:0] key_data,
   input  wire logic        consume,
   output logic             unlocked
);
   typedef enum logic [1:0] {IDLE, GOT_KEY1, OPEN} lock_state_type;
   lock_state_type state_q;

   // any other key write aborts the sequence; window closes after one protected write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= IDLE;
      end else begin
         case (state_q)
            IDLE:     if (key_wr && key_data == UNLOCK_KEY1) state_q <= GOT_KEY1;
            GOT_KEY1: if (key_wr) state_q <= (key_data == UNLOCK_KEY2) ? OPEN : IDLE;
            OPEN:     if (consume) state_q <= IDLE;
            default:  state_q <= IDLE;
         endcase
      end
   end
   assign unlocked = (state_q == OPEN);
endmodule

/* hw/pwm_fault_override_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - polarity bit 1 means fault asserted low; 0 means asserted high.
// - mode 11 ignores fault input; mode 10 reserved, treated as ignored here.
// - mode 01 forces both outputs to override values only while fault present.
// - mode 00 forces both outputs and latches the forced state.
// - with write lock set, output control writes need the unlock sequence first.
module pwm_fault_override_ctrl
   import fault_ovr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [15:0]      rdata,
   input  wire logic        fault_in,
   input  wire logic        output_ctrl_write_lock,
   input  wire logic        pwm_timebase_on,
   input  wire logic        pwm_high_in,
   input  wire logic        pwm_low_in,
   output logic             pwm_high_side_out,
   output logic             pwm_low_side_out,
   output logic [15:0]      output_ctrl_reg,
   output logic             irq
);
   logic [15:0] fault_ctrl_q;
   logic [1:0]  irq_mask_q;
   logic [1:0]  events_q;       // sticky: [0] fault seen, [1] locked write refused
   logic        latched_q;
   logic [15:0] out_ctrl_q;
   logic        fault_active;
   logic        forced;
   logic        fault_polarity_sel;
   logic [1:0]  fault_mode_sel;
   logic [1:0]  fault_override_values;
   logic        unlocked;
   logic        oc_write;
   logic        oc_accept;
   logic        oc_refuse;
   logic        clear_wr;
   logic        status_rd;

   assign fault_polarity_sel    = fault_ctrl_q[POL_BIT];
   assign fault_mode_sel        = fault_ctrl_q[MODE_LSB +: 2];
   assign fault_override_values = {fault_ctrl_q[OVR_LO_BIT], fault_ctrl_q[OVR_HI_BIT]};
   assign clear_wr  = wr_en && addr == CLEAR_ADDR && wdata[0];
   assign status_rd = rd_en && addr == STATUS_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // fault qualification
   // polarity applied
   // disabled or reserved mode ignores input
   always_comb begin
      fault_active = (fault_in ^ fault_polarity_sel)
                   && (fault_mode_sel != MODE_DISABLED)
                   && (fault_mode_sel != MODE_RESERVED);
   end

   // latch held until clear or until the mode leaves latched; a fault in the clear cycle keeps it set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latched_q <= 1'b0;
      end else if (fault_active && fault_mode_sel == MODE_LATCHED) begin
         latched_q <= 1'b1;
      end else if (clear_wr || fault_mode_sel != MODE_LATCHED) begin
         latched_q <= 1'b0;
      end
   end

   // latched mode forces from the fault cycle onward
   // the latch only counts in latched mode: leaving that mode must not keep the
   // pins forced for the one cycle that the latch takes to drop
   assign forced = fault_active || (latched_q && fault_mode_sel == MODE_LATCHED);

   // data outputs registered; one cycle from fault to forced pins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pwm_high_side_out <= 1'b0;
         pwm_low_side_out  <= 1'b0;
      end else begin
         pwm_high_side_out <= forced ? fault_override_values[0] : pwm_high_in;
         pwm_low_side_out  <= forced ? fault_override_values[1] : pwm_low_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output control register with write lock
   assign oc_write  = wr_en && addr == OUT_CTRL_ADDR;
   assign oc_accept = oc_write && (!output_ctrl_write_lock || unlocked);
   assign oc_refuse = oc_write && !oc_accept;

   // any output control write closes an open window, so one unlock buys one write
   unlock_seq u_unlock (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .key_wr   (wr_en && addr == LOCK_KEY_ADDR),
      .key_data (wdata),
      .consume  (oc_write),
      .unlocked (unlocked)
   );

   // output control register; refused writes leave it untouched
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_ctrl_q <= OUT_CTRL_RST;
      end else if (oc_accept) begin
         out_ctrl_q <= wdata;
      end
   end
   assign output_ctrl_reg = out_ctrl_q;

   // fault control register; is software's duty, the write is not blocked
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_ctrl_q <= FAULT_CTRL_RST;
      end else if (wr_en && addr == FAULT_CTRL_ADDR) begin
         // bits 15:6 are not stored, so they always read back zero
         fault_ctrl_q <= {10'h0, wdata[5:0]};
      end
   end

   // interrupt mask, same layout as the sticky event bits
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_en && addr == IRQ_MASK_ADDR) begin
         irq_mask_q <= wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky events: set wins over the read-clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         events_q <= 2'h0;
      end else begin
         events_q[0] <= fault_active || (events_q[0] && !status_rd);
         events_q[1] <= oc_refuse || (events_q[1] && !status_rd);
      end
   end
   assign irq = |(events_q & irq_mask_q);

   // read data one cycle after strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (rd_en) begin
         case (addr)
            FAULT_CTRL_ADDR: rdata <= fault_ctrl_q;
            OUT_CTRL_ADDR:   rdata <= out_ctrl_q;
            STATUS_ADDR:     rdata <= {11'h0, pwm_timebase_on, events_q, latched_q, forced};
            IRQ_MASK_ADDR:   rdata <= {14'h0, irq_mask_q};
            default:         rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   a_polarity_fault: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_mode_sel == MODE_CYCLE && (fault_in ^ fault_polarity_sel))
      |=> pwm_high_side_out == $past(fault_override_values[0]))
      else $error("cycle fault did not force high side");
   a_disabled_ignore: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_mode_sel == MODE_DISABLED) |-> !forced)
      else $error("disabled mode forced outputs");
   a_cycle_release: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_mode_sel == MODE_CYCLE && !fault_active) |=> pwm_low_side_out == $past(pwm_low_in))
      else $error("cycle mode did not release");
   a_latch_set: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_active && fault_mode_sel == MODE_LATCHED) |=> latched_q)
      else $error("latched fault not held");
   a_lock_block: assert property (@(posedge sys_clk) disable iff (rst)
      (oc_write && output_ctrl_write_lock && !unlocked) |=> $stable(out_ctrl_q))
      else $error("locked output control was written");
   a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (latched_q && !clear_wr && fault_mode_sel == MODE_LATCHED) |=> latched_q)
      else $error("latch released without clear");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
      (events_q[0] && irq_mask_q[0]) |-> irq)
      else $error("masked-in event without irq");
   a_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (status_rd && !fault_active) |=> !events_q[0])
      else $error("status read did not clear fault event");
   c_latched_fault: cover property (@(posedge sys_clk) disable iff (rst) latched_q ##1 clear_wr);
   c_cycle_fault: cover property (@(posedge sys_clk) disable iff (rst)
      fault_mode_sel == MODE_CYCLE && fault_active ##1 !fault_active);
   c_unlocked_wr: cover property (@(posedge sys_clk) disable iff (rst)
      oc_accept && output_ctrl_write_lock);
   c_refused_wr: cover property (@(posedge sys_clk) disable iff (rst) oc_refuse);

   ////////////////////////////////////////////////////////////////////////////
   // pin path (one registered stage between forcing decision and pins), reserved mode and latch clear
   a_forced_high: assert property (@(posedge sys_clk) disable iff (rst)
      forced |=> pwm_high_side_out == $past(fault_override_values[0]))
      else $error("forced high side not at override value");
   a_forced_low: assert property (@(posedge sys_clk) disable iff (rst)
      forced |=> pwm_low_side_out == $past(fault_override_values[1]))
      else $error("forced low side not at override value");
   a_free_high: assert property (@(posedge sys_clk) disable iff (rst)
      !forced |=> pwm_high_side_out == $past(pwm_high_in))
      else $error("unforced high side not following generator");
   a_reserved_ignore: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_mode_sel == MODE_RESERVED) |-> !fault_active)
      else $error("reserved mode took the fault input");
   a_latch_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (clear_wr && !fault_active && fault_mode_sel == MODE_LATCHED) |=> !latched_q)
      else $error("clear write did not release latch");

   // lock, events and read port
   a_window_close: assert property (@(posedge sys_clk) disable iff (rst)
      (oc_write && unlocked) |=> !unlocked)
      else $error("unlock window still open after a write");
   a_refused_event: assert property (@(posedge sys_clk) disable iff (rst)
      oc_refuse |=> events_q[1])
      else $error("refused write did not set its event");
   a_irq_refused: assert property (@(posedge sys_clk) disable iff (rst)
      (events_q[1] && irq_mask_q[1]) |-> irq)
      else $error("masked-in refusal without irq");
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
      !rd_en |=> rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
   import fault_ovr_pkg::*;
;
   logic        sys_clk, rst, wr_en, rd_en, fault_in, output_ctrl_write_lock;
   logic        pwm_timebase_on, pwm_high_in, pwm_low_in, hi_o, lo_o, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, oc_reg, v, rv;
   int          err_total, tests_run;
   logic [1:0]  md, ov;
   logic        pol;
   pwm_fault_override_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fault_in(fault_in),
      .output_ctrl_write_lock(output_ctrl_write_lock), .pwm_timebase_on(pwm_timebase_on),
      .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .pwm_high_side_out(hi_o),
      .pwm_low_side_out(lo_o), .output_ctrl_reg(oc_reg), .irq(irq));
   // free-running 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   // expected pin: override value while the fault counts, else the generator level
   function automatic logic exp_pin(logic p, logic [1:0] m, logic f, logic o, logic i);
      return ((f ^ p) && !m[1]) ? o : i;
   endfunction
   initial begin
      {wr_en, rd_en, fault_in, output_ctrl_write_lock, pwm_timebase_on} = '0;
      {pwm_high_in, pwm_low_in, addr, wdata, err_total, tests_run} = '0;
      rst = 1'b1;
      void'($urandom(32'h52d1));
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(FAULT_CTRL_ADDR, v); chk(v, FAULT_CTRL_RST); // disabled at reset
      rd(4'hf, v); chk(v, 16'h0000);
      // every polarity and mode, random fault level and generator levels
      for (int i = 0; i < 48; i++) begin
         pol = (i < 8) ? i[2] : 1'($urandom);
         md  = (i < 8) ? i[1:0] : 2'($urandom);
         ov  = 2'($urandom);
         wr(FAULT_CTRL_ADDR, 16'h0003);
         fault_in <= (i < 8) ? i[0] ^ i[2] ^ 1'b1 : 1'($urandom);
         {pwm_high_in, pwm_low_in} <= 2'($urandom);
         // polarity only changed with the time base off
         pwm_timebase_on <= 1'b0;
         wr(FAULT_CTRL_ADDR, {10'($urandom), ov[0], ov[1], 1'b0, pol, md});
         settle();
         chk(hi_o, exp_pin(pol, md, fault_in, ov[1], pwm_high_in));
         chk(lo_o, exp_pin(pol, md, fault_in, ov[0], pwm_low_in));
         rd(FAULT_CTRL_ADDR, rv);
         chk(rv, {10'h0, ov[0], ov[1], 1'b0, pol, md});
      end
      // latched mode, active-low source: stays forced after the fault leaves
      wr(FAULT_CTRL_ADDR, 16'h0003);
      fault_in <= 1'b1; pwm_high_in <= 1'b0; pwm_low_in <= 1'b1;
      rd(STATUS_ADDR, v);
      wr(IRQ_MASK_ADDR, 16'h0001);
      wr(FAULT_CTRL_ADDR, 16'h0014);
      fault_in <= 1'b0;
      settle();
      chk(irq, 1'b1); // fault event raises irq
      @(posedge sys_clk);
      fault_in <= 1'b1;
      settle();
      chk({hi_o, lo_o}, 2'b10); // held after release
      @(posedge sys_clk);
      pwm_timebase_on <= 1'b1;
      settle();
      rd(STATUS_ADDR, v); chk(v[4:0], 5'h17); // latched, forced, event, time base
      #1 chk(irq, 1'b0);
      wr(CLEAR_ADDR, 16'h0001);
      settle();
      chk({hi_o, lo_o}, 2'b01); // clear releases
      // cycle mode: released as soon as the fault leaves
      wr(FAULT_CTRL_ADDR, 16'h0015);
      fault_in <= 1'b0;
      settle();
      chk({hi_o, lo_o}, 2'b10); // forced
      @(posedge sys_clk);
      fault_in <= 1'b1;
      settle();
      chk({hi_o, lo_o}, 2'b01); // released
      // locked writes refused until the two keys arrive
      @(posedge sys_clk);
      output_ctrl_write_lock <= 1'b1;
      wr(IRQ_MASK_ADDR, 16'h0002);
      rd(IRQ_MASK_ADDR, rv); chk(rv, 16'h0002); // refusal interrupt enabled
      wr(OUT_CTRL_ADDR, 16'h5a5a);
      settle();
      chk(oc_reg, OUT_CTRL_RST); // refused
      chk(irq, 1'b1); // refusal event
      rd(STATUS_ADDR, v); chk(v[3], 1'b1); // sticky refusal
      #1 chk(irq, 1'b0);
      wr(LOCK_KEY_ADDR, UNLOCK_KEY1);
      wr(LOCK_KEY_ADDR, UNLOCK_KEY2);
      v = 16'($urandom);
      wr(OUT_CTRL_ADDR, v);
      settle();
      chk(oc_reg, v); // accepted after unlock
      wr(OUT_CTRL_ADDR, ~v);
      settle();
      chk(oc_reg, v); // window closed again
      rd(OUT_CTRL_ADDR, rv); chk(rv, v);
      @(posedge sys_clk);
      output_ctrl_write_lock <= 1'b0;
      wr(OUT_CTRL_ADDR, ~v);
      settle();
      chk(oc_reg, ~v); // free with lock off
      tally_and_finish();
   end
endmodule
